// ---- design/alu_pkg.sv ----
/*
  Shared constants and types for the add/and datapath block: APB register
  map, status field positions, reset values, opcode prefixes, phase and
  operation encodings, and the structs that carry flags and results.
  Assumes a 32-bit APB bus with byte addresses and one word per register.
*/
package alu_pkg;

  // APB geometry
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;

  // Register byte offsets
  localparam logic [APB_AW-1:0] REG_INSTR = 8'h00;
  localparam logic [APB_AW-1:0] REG_ACC = 8'h04;
  localparam logic [APB_AW-1:0] REG_STATUS = 8'h08;
  localparam logic [APB_AW-1:0] REG_RESULT = 8'h0C;
  localparam logic [APB_AW-1:0] REG_COUNT = 8'h10;
  localparam logic [APB_AW-1:0] REG_PHASE = 8'h14;

  // Status register fields
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_NIBBLE = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_BUSY = 3;
  localparam int unsigned ST_ILLEGAL = 4;
  localparam int unsigned ST_DONE = 5;

  // Result register fields
  localparam int unsigned RES_DEST = 8;
  localparam int unsigned RES_FADDR_LSB = 9;

  // Instruction word geometry
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned COUNT_W = 16;

  // Opcode prefixes, upper bits of the instruction word
  localparam logic [4:0] ADD_IMM_PFX = 5'h1F;
  localparam logic [5:0] AND_IMM_PFX = 6'h39;
  localparam logic [5:0] ADD_FILE_PFX = 6'h07;
  localparam logic [5:0] AND_FILE_PFX_DEF = 6'h05;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ADD_IMM = 3'b001,
    OP_AND_IMM = 3'b010,
    OP_ADD_FILE = 3'b011,
    OP_AND_FILE = 3'b100
  } op_e;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_DECODE = 3'b001,
    PH_READ = 3'b010,
    PH_PROC = 3'b011,
    PH_WRITE = 3'b100
  } phase_e;

  // Bit order matches the status register: z at 2, nibble at 1, c at 0
  typedef struct packed {
    logic z;
    logic nibble_carry_flag;
    logic c;
  } flags_s;

  typedef struct packed {
    op_e op;
    logic dest;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0] lit;
  } decoded_s;

  typedef struct packed {
    logic [DATA_W-1:0] res;
    flags_s flags;
  } alu_out_s;

  localparam flags_s FLAGS_RST = 3'b000;

endpackage : alu_pkg

// ---- design/alu_core.sv ----
/*
  Combinational arithmetic/logic unit for the add and and operations.
  Assumes the caller registers the output and decides when flags commit.
*/
`timescale 1ns/100ps
module alu_core (
  // Operation and operands
  input wire alu_pkg::op_e i_op,
  input wire logic [alu_pkg::DATA_W-1:0] i_a,
  input wire logic [alu_pkg::DATA_W-1:0] i_b,
  input wire alu_pkg::flags_s i_flags,
  // Result with updated flags
  output alu_pkg::alu_out_s o_out
);
  import alu_pkg::*;

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  logic [DATA_W:0] full_sum;
  logic [4:0] low_sum;

  always_comb begin
    full_sum = {1'b0, i_a} + {1'b0, i_b};
    low_sum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
    o_out.res = i_a;
    o_out.flags = i_flags;
    case (i_op)
      OP_ADD_IMM, OP_ADD_FILE: begin
        o_out.res = full_sum[DATA_W-1:0]; // RQ1
        o_out.flags.c = full_sum[DATA_W]; // RQ8
        o_out.flags.nibble_carry_flag = low_sum[4]; // RQ8
        o_out.flags.z = is_zero(full_sum[DATA_W-1:0]); // RQ4
      end
      OP_AND_IMM, OP_AND_FILE: begin
        // Carry bits pass through untouched
        o_out.res = i_a & i_b; // RQ2
        o_out.flags.z = is_zero(i_a & i_b); // RQ6
      end
      default: begin
        o_out.res = i_a;
      end
    endcase
  end

endmodule : alu_core

// ---- design/add_and_literal_file_alu.sv ----
/*
  Four-phase execution unit for add/and with literal or file operand,
  with an APB register interface and a port to an external file register.
  Assumes the file register answers a read combinationally in the same
  cycle as the read strobe, on the same clock as this block.
*/
// What this block does
// (RQ1) Add-immediate opcode adds literal to accumulator, updates C, nibble, Z.
// (RQ2) And-immediate opcode ANDs literal into accumulator, only Z changes.
// (RQ3) Add-file opcode carries dest bit and 7-bit address, adds file to acc.
// (RQ4) Add-file updates carry, nibble carry and zero from its sum.
// (RQ5) File ops write accumulator when dest is 0, file register when 1.
// (RQ6) And-file ANDs accumulator with file, result to dest, only Z changes.
// (RQ7) One word, four cycles: decode, read, process, write phases in order.
// (RQ8) Z set on zero result; carry from bit 7, nibble carry from bit 3.
`timescale 1ns/100ps
module add_and_literal_file_alu #(
  parameter logic [5:0] AND_FILE_PFX = alu_pkg::AND_FILE_PFX_DEF
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [alu_pkg::APB_AW-1:0] I_PADDR,
  input wire logic [alu_pkg::APB_DW-1:0] I_PWDATA,
  output logic [alu_pkg::APB_DW-1:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // File register port
  output logic [alu_pkg::FADDR_W-1:0] O_FILE_ADDR,
  output logic O_FILE_RE,
  input wire logic [alu_pkg::DATA_W-1:0] I_FILE_RDATA,
  output logic O_FILE_WE,
  output logic [alu_pkg::DATA_W-1:0] O_FILE_WDATA,
  // Core state
  output logic O_BUSY,
  output alu_pkg::flags_s O_FLAGS
);
  import alu_pkg::*;

  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    case (a)
      REG_INSTR, REG_ACC, REG_STATUS: is_mapped = 1'b1;
      REG_RESULT, REG_COUNT, REG_PHASE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  function automatic logic is_writable(input logic [APB_AW-1:0] a);
    is_writable = (a == REG_INSTR) || (a == REG_ACC) || (a == REG_STATUS);
  endfunction : is_writable

  // Words outside the four prefixes decode to OP_NONE; the sequencer then
  // drops back to idle after decode and the word is flagged as illegal
  function automatic decoded_s decode(input logic [INSTR_W-1:0] w,
                                      input logic [5:0] and_file);
    decode.dest = w[DEST_BIT];
    decode.faddr = w[FADDR_W-1:0];
    decode.lit = w[DATA_W-1:0];
    if (w[13:9] == ADD_IMM_PFX) begin
      decode.op = OP_ADD_IMM; // RQ1
    end else if (w[13:8] == AND_IMM_PFX) begin
      decode.op = OP_AND_IMM; // RQ2
    end else if (w[13:8] == ADD_FILE_PFX) begin
      decode.op = OP_ADD_FILE; // RQ3
    end else if (w[13:8] == and_file) begin
      decode.op = OP_AND_FILE; // RQ6
    end else begin
      decode.op = OP_NONE;
    end
  endfunction : decode

  function automatic logic is_file_op(input op_e op);
    is_file_op = (op == OP_ADD_FILE) || (op == OP_AND_FILE);
  endfunction : is_file_op

  phase_e phase;
  phase_e next_phase;
  logic [INSTR_W-1:0] instr;
  decoded_s dec;
  logic [DATA_W-1:0] acc;
  flags_s flags;
  logic [DATA_W-1:0] operand;
  alu_out_s alu_out;
  alu_out_s result;
  logic illegal;
  logic done;
  logic [COUNT_W-1:0] retired;
  logic [DATA_W-1:0] last_res;
  logic last_dest;
  logic [FADDR_W-1:0] last_faddr;
  logic busy;
  logic access;
  logic wr_ok;
  logic bus_err;
  logic start;
  logic to_file;

  assign busy = (phase != PH_IDLE);
  assign access = I_PSEL && I_PENABLE;
  // Writes to state the datapath owns are refused mid-instruction, so
  // software can never race the write phase
  assign bus_err = !is_mapped(I_PADDR) ||
                   (I_PWRITE && (!is_writable(I_PADDR) || busy));
  assign wr_ok = access && I_PWRITE && !bus_err;
  assign start = wr_ok && (I_PADDR == REG_INSTR);
  assign to_file = is_file_op(dec.op) && dec.dest; // RQ5

  // No wait states: every register is ready in its first access cycle
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access && bus_err;
  assign O_BUSY = busy;
  assign O_FLAGS = flags;
  assign O_FILE_RE = (phase == PH_READ) && is_file_op(dec.op); // RQ7
  assign O_FILE_WE = (phase == PH_WRITE) && to_file; // RQ5
  // Driven from the decoded word, so it stays put from read to write phase
  assign O_FILE_ADDR = dec.faddr;

  // Flags feed back so the and ops keep the carry bits they do not touch
  alu_core alu_core_i (
    .i_op(dec.op),
    .i_a(acc),
    .i_b(operand),
    .i_flags(flags),
    .o_out(alu_out)
  );

  // Phase sequencer: one legal instruction word runs through four phases; an illegal one stops after decode
  always_comb begin
    next_phase = phase;
    case (phase)
      PH_IDLE: begin
        if (start) begin
          next_phase = PH_DECODE;
        end
      end
      PH_DECODE: begin
        if (decode(instr, AND_FILE_PFX).op == OP_NONE) begin
          next_phase = PH_IDLE;
        end else begin
          next_phase = PH_READ; // RQ7
        end
      end
      PH_READ: next_phase = PH_PROC; // RQ7
      PH_PROC: next_phase = PH_WRITE; // RQ7
      PH_WRITE: next_phase = PH_IDLE; // RQ7
      default: next_phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      phase <= PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Instruction word capture
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      instr <= INSTR_RST;
    end else if (start) begin
      instr <= I_PWDATA[INSTR_W-1:0];
    end
  end

  // Decode phase
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      dec <= '0;
    end else if (phase == PH_DECODE) begin
      dec <= decode(instr, AND_FILE_PFX); // RQ7
    end
  end

  // Operand read phase: literal or addressed file register
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      operand <= 8'h00;
    end else if (phase == PH_READ) begin
      if (is_file_op(dec.op)) begin
        operand <= I_FILE_RDATA; // RQ3
      end else begin
        operand <= dec.lit; // RQ1
      end
    end
  end

  // Process phase
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      result <= '0;
    end else if (phase == PH_PROC) begin
      result <= alu_out; // RQ7
    end
  end

  // File write data is held from the process phase through the write
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_FILE_WDATA <= 8'h00;
    end else if (phase == PH_PROC) begin
      O_FILE_WDATA <= alu_out.res;
    end
  end

  // Accumulator: result in write phase unless routed to the file
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      acc <= ACC_RST;
    end else if (phase == PH_WRITE && !to_file) begin
      acc <= result.res; // RQ5
    end else if (wr_ok && I_PADDR == REG_ACC) begin
      acc <= I_PWDATA[DATA_W-1:0];
    end
  end

  // Flags commit in the write phase; the unit leaves unaffected bits alone
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      flags <= FLAGS_RST;
    end else if (phase == PH_WRITE) begin
      flags <= result.flags; // RQ8
    end else if (wr_ok && I_PADDR == REG_STATUS) begin
      flags.c <= I_PWDATA[ST_C];
      flags.nibble_carry_flag <= I_PWDATA[ST_NIBBLE];
      flags.z <= I_PWDATA[ST_Z];
    end
  end

  // Sticky flags, cleared by writing one; a new event wins over the clear
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      illegal <= 1'b0;
    end else if (phase == PH_DECODE &&
                 decode(instr, AND_FILE_PFX).op == OP_NONE) begin
      illegal <= 1'b1;
    end else if (wr_ok && I_PADDR == REG_STATUS && I_PWDATA[ST_ILLEGAL]) begin
      illegal <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      done <= 1'b0;
    end else if (phase == PH_WRITE) begin
      done <= 1'b1;
    end else if (wr_ok && I_PADDR == REG_STATUS && I_PWDATA[ST_DONE]) begin
      done <= 1'b0;
    end
  end

  // Retired instruction count and last result record
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      retired <= 16'h0000;
    end else if (phase == PH_WRITE) begin
      retired <= retired + 16'h0001;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      last_res <= 8'h00;
      last_dest <= 1'b0;
      last_faddr <= 7'h00;
    end else if (phase == PH_WRITE) begin
      last_res <= result.res;
      last_dest <= to_file;
      last_faddr <= dec.faddr;
    end
  end

  // Read data is registered in the setup phase so it is stable in access
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      O_PRDATA <= 32'h0000_0000;
      case (I_PADDR)
        REG_INSTR: O_PRDATA[INSTR_W-1:0] <= instr;
        REG_ACC: O_PRDATA[DATA_W-1:0] <= acc;
        REG_STATUS: begin
          O_PRDATA[ST_Z:ST_C] <= flags;
          O_PRDATA[ST_BUSY] <= busy;
          O_PRDATA[ST_ILLEGAL] <= illegal;
          O_PRDATA[ST_DONE] <= done;
        end
        REG_RESULT: begin
          O_PRDATA[DATA_W-1:0] <= last_res;
          O_PRDATA[RES_DEST] <= last_dest;
          O_PRDATA[RES_FADDR_LSB+FADDR_W-1:RES_FADDR_LSB] <= last_faddr;
        end
        REG_COUNT: O_PRDATA[COUNT_W-1:0] <= retired;
        REG_PHASE: O_PRDATA[2:0] <= phase;
        default: O_PRDATA <= 32'h0000_0000;
      endcase
    end
  end

endmodule : add_and_literal_file_alu

// ---- test/alu_chk_asserts.sv ----
/*
  Port checker for the add/and datapath block.
  Assumes one clock and a synchronous active-low reset; bound below.
*/
`timescale 1ns/100ps
module alu_chk (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // Watched outputs
  input wire logic O_FILE_RE,
  input wire logic O_FILE_WE,
  input wire logic [alu_pkg::FADDR_W-1:0] O_FILE_ADDR,
  input wire logic [alu_pkg::DATA_W-1:0] O_FILE_WDATA,
  input wire logic O_BUSY,
  input wire alu_pkg::flags_s O_FLAGS
);
  import alu_pkg::*;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  // An illegal word holds busy for the decode cycle only, so it is left out
  a_busy_four: assert property (
    $rose(O_BUSY) ##1 O_BUSY |-> O_BUSY [*3] ##1 !O_BUSY)
    else $error("busy span is not four cycles");
  a_read_second: assert property (
    O_FILE_RE |-> $past(O_BUSY) && !$past(O_BUSY, 2))
    else $error("file read outside second phase");
  a_read_pulse: assert property (
    O_FILE_RE |=> !O_FILE_RE)
    else $error("file read longer than one cycle");
  a_write_after_read: assert property (
    O_FILE_WE |-> $past(O_FILE_RE, 2))
    else $error("file write without read two cycles before");
  a_write_last: assert property (
    O_FILE_WE |=> !O_BUSY)
    else $error("file write not in last phase");
  a_addr_held: assert property (
    O_FILE_RE |=> $stable(O_FILE_ADDR) [*2])
    else $error("file address moved during operation");
  a_zero_flag: assert property (
    O_FILE_WE |=> O_FLAGS.z == ($past(O_FILE_WDATA) == 8'h00))
    else $error("zero flag disagrees with result");
  a_flags_hold: assert property (
    O_BUSY && $past(O_BUSY) |-> $stable(O_FLAGS))
    else $error("flags changed before the write phase ended");

  c_file_write: cover property (O_FILE_WE);
  c_file_to_acc: cover property (O_FILE_RE ##2 !O_FILE_WE);
  c_carry_out: cover property ($fell(O_BUSY) && O_FLAGS.c);
endmodule : alu_chk

bind add_and_literal_file_alu alu_chk alu_chk_i (
  .I_CLK_SYS(I_CLK_SYS),
  .I_RST_N(I_RST_N),
  .O_FILE_RE(O_FILE_RE),
  .O_FILE_WE(O_FILE_WE),
  .O_FILE_ADDR(O_FILE_ADDR),
  .O_FILE_WDATA(O_FILE_WDATA),
  .O_BUSY(O_BUSY),
  .O_FLAGS(O_FLAGS)
);

// ---- test/add_and_literal_file_alu_tb_top.sv ----
/*
  Self-checking bench: APB master, file register stand-in, integer model.
  Assumes zero-wait APB and a held file data byte during each operation.
*/
`timescale 1ns/100ps
module add_and_literal_file_alu_tb_top;
  import alu_pkg::*;
  logic clk, rst_n, psel, pen, pwr, pready, perr, fre, fwe, busy, e, dst;
  logic [7:0] paddr, fdata, fwd, av, bv;
  logic [31:0] pwdata, prdata, r;
  logic [6:0] faddr, fv;
  logic [13:0] ins;
  flags_s flags;
  int err_total, total_checks, seed, c, nc, z;
  int wcnt = 0;
  int wd = 0;
  int wa = 0;
  int i, n, op, res, accm, w0;

  add_and_literal_file_alu #(.AND_FILE_PFX(AND_FILE_PFX_DEF))
  add_and_literal_file_alu_i (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr),
    .O_FILE_ADDR(faddr), .O_FILE_RE(fre), .I_FILE_RDATA(fdata),
    .O_FILE_WE(fwe), .O_FILE_WDATA(fwd), .O_BUSY(busy), .O_FLAGS(flags));

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  // Capture file writes so a stray or missing one is counted
  always @(posedge clk) if (fwe === 1'b1) begin
    wcnt <= wcnt + 1;
    wd <= fwd;
    wa <= faddr;
  end

  task final_report;
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20) err_total++;
    r = prdata;
    e = perr;
    psel <= 0;
    pen <= 0;
  endtask : apb

  initial begin
    #3000000;
    err_total++;
    final_report;
  end

  initial begin
    {rst_n, psel, pen, pwr, paddr, pwdata, fdata} = '0;
    {err_total, total_checks, c, nc, z} = '0;
    seed = 42436;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    apb(0, 8'h20, 0);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, r);
    apb(1, REG_RESULT, 1);
    chk("ro err", 1, e);
    for (i = 0; i < 42; i++) begin
      op = i % 7;
      av = $random(seed);
      bv = $random(seed);
      fv = $random(seed);
      // Corners first: full carry with zero, then nibble carry alone
      if (i < 14) av = (i < 7) ? 8'hFF : 8'h0F;
      if (i < 14) bv = 8'h01;
      apb(1, REG_ACC, {24'h0, av});
      fdata <= bv;
      case (op)
        0, 1: ins = {ADD_IMM_PFX, op[0], bv};
        2: ins = {AND_IMM_PFX, bv};
        3, 4: ins = {ADD_FILE_PFX, op == 4, fv};
        default: ins = {AND_FILE_PFX_DEF, op == 6, fv};
      endcase
      dst = (op == 4 || op == 6);
      if (op != 2 && op != 5 && op != 6) begin
        res = av + bv;
        c = res >> 8;
        nc = ((av & 15) + (bv & 15)) >> 4;
        res = res & 255;
      end else res = av & bv;
      z = (res == 0);
      accm = dst ? av : res;
      w0 = wcnt;
      apb(1, REG_INSTR, {18'h0, ins});
      chk("instr err", 0, e);
      n = 0;
      @(posedge clk);
      while (busy === 1'b1 && n < 9) begin
        n++;
        @(posedge clk);
      end
      chk("busy cycles", 4, n);
      apb(0, REG_ACC, 0);
      chk("acc", accm, r & 32'hFF);
      chk("flags", {z[0], nc[0], c[0]}, flags);
      chk("file writes", w0 + dst, wcnt);
      if (dst) chk("file data", res, wd);
      if (dst) chk("file addr", fv, wa);
    end
    // Unlisted word: dropped after decode, sticky illegal set, no retire
    apb(1, REG_INSTR, 32'h0000_0000);
    chk("illegal err", 0, e);
    apb(0, REG_STATUS, 0);
    chk("status", {26'h0, 2'b11, 1'b0, z[0], nc[0], c[0]}, r);
    apb(0, REG_COUNT, 0);
    chk("count", 42, r);
    // Writing ones clears both sticky bits and keeps the flags
    apb(1, REG_STATUS, {26'h0, 2'b11, 1'b0, z[0], nc[0], c[0]});
    apb(0, REG_STATUS, 0);
    chk("status clr", {26'h0, 2'b00, 1'b0, z[0], nc[0], c[0]}, r);
    final_report;
  end
endmodule : add_and_literal_file_alu_tb_top
